// ==== src/dso_map.svh ====
// Register offsets, function codes, reset values and timing for the status output block
`ifndef DSO_MAP_SVH
`define DSO_MAP_SVH

// Register byte offsets
`define DSO_REG_CODE0       8'h00
`define DSO_REG_CODE1       8'h04
`define DSO_REG_CODE2       8'h08
`define DSO_REG_CODE3       8'h0C
`define DSO_REG_CODE4       8'h10
`define DSO_REG_CTRL        8'h14
`define DSO_REG_STATUS      8'h18
`define DSO_REG_TERM        8'h1C

// Field positions
`define DSO_CTRL_HW_OC_EN   0
`define DSO_STAT_REJECT     0
`define DSO_STAT_FLAGS_LSB  1

// Function codes (positive logic); negative logic adds the offset
`define DSO_CODE_RUNNING    11'h000
`define DSO_CODE_UNDERVOLT  11'h003
`define DSO_CODE_TORQUE_POL 11'h004
`define DSO_CODE_LIMITING   11'h005
`define DSO_CODE_KEYPAD     11'h008
`define DSO_CODE_READY      11'h00A
`define DSO_CODE_NONEG_LO   11'h00B
`define DSO_CODE_NONEG_HI   11'h00D
`define DSO_CODE_CONTACTOR  11'h00F
`define DSO_CODE_LIMIT_DLY  11'h016
`define DSO_CODE_OUTPUT_ON  11'h023
`define DSO_CODE_ANY_ALARM  11'h063
`define DSO_CODE_CUSTOM_LO  11'h06F
`define DSO_CODE_CUSTOM_HI  11'h073
`define DSO_CODE_NEG_OFFSET 11'h3E8

// Reset code of each terminal and reset value of the control register
`define DSO_RST_CODE0       11'h000
`define DSO_RST_CODE1       11'h003
`define DSO_RST_CODE2       11'h005
`define DSO_RST_CODE3       11'h00A
`define DSO_RST_CODE4       11'h063
`define DSO_RST_CTRL        1'h0

// Timing
`define DSO_CLK_HZ          25000000
`define DSO_LIMIT_MIN_MS    100
`define DSO_LIMIT_DLY_MS    20

`endif

// ==== src/dso_pkg.sv ====
// Types shared by the status output block
package dso_pkg;

   localparam int DSO_NUM_TERM = 5;

   typedef logic [10:0] dso_code_t;

   // Internal drive state sampled every control cycle
   typedef struct packed {
      logic       freq_above_start;
      logic       freq_below_stop;
      logic       dc_braking;
      logic       dew_prevention;
      logic       pre_exciting;
      logic       zero_speed_ctl;
      logic       servo_lock;
      logic       vector_mode;
      logic       dc_link_below_uv;
      logic       uv_trip;
      logic       torque_braking;
      logic       torque_limiting;
      logic       sw_current_limiting;
      logic       hw_oc_limiting;
      logic       anti_regen_decel;
      logic       keypad_run_source;
      logic       prep_done;
      logic       protective_active;
      logic       forward_run_command;
      logic       run_command;
      logic       stop_command;
      logic       motor_stopped;
      logic       coast_command;
      logic       any_alarm;
      logic [4:0] custom_logic;
   } dso_state_s;

   // Contactor control sequence
   typedef enum logic [2:0] {
      DSO_AX_OFF      = 3'b001,
      DSO_AX_ON       = 3'b010,
      DSO_AX_STOPPING = 3'b100
   } dso_ax_e;

endpackage : dso_pkg

// ==== src/dso_top.sv ====
// Status output terminal logic of the motor drive
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`include "dso_map.svh"

// Function
// - Negative-logic code of each function equals its positive code plus 1000.
// - Negative-logic assignment of a function without a negative code is rejected.
// - Running and output-on assert above starting frequency, deassert below stop.
// - Negative-logic running or output-on terminal shows the stopped state.
// - Running output is off during DC braking and dew prevention.
// - Output-on stays on during braking, pre-excite, zero speed, dew prevention.
// - Vector control: zero-speed or servo-lock asserts running and output-on.
// - Undervoltage flag follows DC link below configured undervoltage level.
// - Undervoltage flag stays on while undervoltage trip holds the drive.
// - Run commands are ignored while the undervoltage flag is on.
// - Torque polarity output low when driving, high when braking.
// - Limiting flag on during any limiting, each pulse at least 100 ms.
// - Delayed limiting flag on after 20 ms of continuous limiting.
// - Limiting sources: torque, software current, enabled hardware overcurrent, anti-regen.
// - Keypad source flag on while keypad keys are the run source.
// - Ready flag on when preparation done and no protection active.
// - Contactor on at forward run, off after stop command and motor stopped.
// - Contactor off at once on coast-to-stop or any alarm.
// - Custom logic outputs one to five use codes 111 to 115.
module dso_top
   import dso_pkg::*;
#(
   parameter int LIMIT_MIN_CYC = `DSO_LIMIT_MIN_MS * (`DSO_CLK_HZ / 1000),
   parameter int LIMIT_DLY_CYC = `DSO_LIMIT_DLY_MS * (`DSO_CLK_HZ / 1000)
) (
   // Clock and reset
   input  wire logic                    CLK_I,
   input  wire logic                    RST_I,
   // Register port
   input  wire logic [7:0]              ADDR_I,
   input  wire logic [31:0]             WDATA_I,
   input  wire logic                    WR_I,
   input  wire logic                    RD_I,
   output logic      [31:0]             RDATA_O,
   // Drive state
   input  wire dso_state_s              STATE_I,
   // Run command gate towards the sequencer
   output logic                         RUN_CMD_ENABLE_O,
   // Digital output terminals
   output logic      [DSO_NUM_TERM-1:0] TERM_O
);

   localparam logic [21:0] LIMIT_MIN = LIMIT_MIN_CYC[21:0];
   localparam logic [21:0] LIMIT_DLY = LIMIT_DLY_CYC[21:0];

   // Internal flags, one per implemented function except the custom logic outputs
   typedef struct packed {
      logic running;
      logic output_on;
      logic undervoltage_flag;
      logic torque_polarity;
      logic output_limiting_flag;
      logic output_limiting_delayed_flag;
      logic keypad_run_source_flag;
      logic ready;
      logic supply_contactor_control;
      logic any_alarm_flag;
   } dso_flags_s;

   // Code decode: valid when the code names a function that may be assigned
   function automatic logic dso_code_ok(input dso_code_t code);
      dso_code_t base;
      logic      neg;
      logic      ok;
      neg  = (code >= `DSO_CODE_NEG_OFFSET);
      base = neg ? code - `DSO_CODE_NEG_OFFSET : code;
      case (base)
         `DSO_CODE_RUNNING, `DSO_CODE_UNDERVOLT, `DSO_CODE_TORQUE_POL,
         `DSO_CODE_LIMITING, `DSO_CODE_KEYPAD, `DSO_CODE_READY,
         `DSO_CODE_CONTACTOR, `DSO_CODE_LIMIT_DLY, `DSO_CODE_OUTPUT_ON,
         `DSO_CODE_ANY_ALARM: ok = 1'b1;
         default: begin
            ok = (base >= `DSO_CODE_CUSTOM_LO) && (base <= `DSO_CODE_CUSTOM_HI);
            // Functions with no active-off variant accept only positive logic
            if ((base >= `DSO_CODE_NONEG_LO) && (base <= `DSO_CODE_NONEG_HI)) begin
               ok = !neg;
            end
         end
      endcase
      return ok;
   endfunction : dso_code_ok

   // Terminal level for one stored code
   function automatic logic dso_select(input dso_code_t code, input dso_flags_s f,
                                       input logic [4:0] custom);
      dso_code_t base;
      logic      neg;
      logic      lvl;
      neg  = (code >= `DSO_CODE_NEG_OFFSET);
      base = neg ? code - `DSO_CODE_NEG_OFFSET : code;
      case (base)
         `DSO_CODE_RUNNING:    lvl = f.running;
         `DSO_CODE_OUTPUT_ON:  lvl = f.output_on;
         `DSO_CODE_UNDERVOLT:  lvl = f.undervoltage_flag;
         `DSO_CODE_TORQUE_POL: lvl = f.torque_polarity;
         `DSO_CODE_LIMITING:   lvl = f.output_limiting_flag;
         `DSO_CODE_LIMIT_DLY:  lvl = f.output_limiting_delayed_flag;
         `DSO_CODE_KEYPAD:     lvl = f.keypad_run_source_flag;
         `DSO_CODE_READY:      lvl = f.ready;
         `DSO_CODE_CONTACTOR:  lvl = f.supply_contactor_control;
         `DSO_CODE_ANY_ALARM:  lvl = f.any_alarm_flag;
         default: begin
            lvl = 1'b0;
            if ((base >= `DSO_CODE_CUSTOM_LO) && (base <= `DSO_CODE_CUSTOM_HI)) begin
               lvl = custom[3'(base - `DSO_CODE_CUSTOM_LO)];
            end
         end
      endcase
      // Negative logic inverts, so running shows the stopped state
      return lvl ^ neg;
   endfunction : dso_select

   // Configuration and status state
   dso_code_t        code      [DSO_NUM_TERM];
   dso_code_t        next_code [DSO_NUM_TERM];
   logic             hw_oc_en;
   logic             next_hw_oc_en;
   logic             reject;
   logic             next_reject;
   logic [31:0]      next_rdata;

   // Drive condition state
   logic             run_state;
   logic             next_run_state;
   logic [21:0]      hold_cnt;
   logic [21:0]      next_hold_cnt;
   logic [21:0]      dly_cnt;
   logic [21:0]      next_dly_cnt;
   dso_ax_e          ax_state;
   dso_ax_e          next_ax_state;
   dso_flags_s       flags;
   dso_flags_s       next_flags;
   logic [DSO_NUM_TERM-1:0] next_term;
   logic             next_run_enable;
   logic             limit_any;
   logic             vec_hold;

   // Register writes; a refused code leaves the old one in place
   always_comb begin
      dso_code_t wcode;
      wcode         = WDATA_I[10:0];
      next_hw_oc_en = hw_oc_en;
      next_reject   = reject;
      for (int i = 0; i < DSO_NUM_TERM; i++) begin
         next_code[i] = code[i];
      end
      if (WR_I) begin
         if (ADDR_I == `DSO_REG_CTRL) begin
            next_hw_oc_en = WDATA_I[`DSO_CTRL_HW_OC_EN];
         end else if (ADDR_I == `DSO_REG_STATUS && WDATA_I[`DSO_STAT_REJECT]) begin
            next_reject = 1'b0; // Write one to clear
         end
         for (int i = 0; i < DSO_NUM_TERM; i++) begin
            if (ADDR_I == 8'(4 * i)) begin
               if (dso_code_ok(wcode) && WDATA_I[31:11] == 21'h00_0000) begin
                  next_code[i] = wcode;
               end else begin
                  next_reject = 1'b1;
               end
            end
         end
      end
   end

   // Read data stands in the cycle after the strobe only
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (RD_I) begin
         case (ADDR_I)
            `DSO_REG_CODE0:  next_rdata = {21'h00_0000, code[0]};
            `DSO_REG_CODE1:  next_rdata = {21'h00_0000, code[1]};
            `DSO_REG_CODE2:  next_rdata = {21'h00_0000, code[2]};
            `DSO_REG_CODE3:  next_rdata = {21'h00_0000, code[3]};
            `DSO_REG_CODE4:  next_rdata = {21'h00_0000, code[4]};
            `DSO_REG_CTRL:   next_rdata = {31'h0000_0000, hw_oc_en};
            `DSO_REG_STATUS: next_rdata = {21'h00_0000, flags, reject};
            `DSO_REG_TERM:   next_rdata = {27'h000_0000, TERM_O};
            default:         next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         code[0]  <= `DSO_RST_CODE0;
         code[1]  <= `DSO_RST_CODE1;
         code[2]  <= `DSO_RST_CODE2;
         code[3]  <= `DSO_RST_CODE3;
         code[4]  <= `DSO_RST_CODE4;
         hw_oc_en <= `DSO_RST_CTRL;
         reject   <= 1'b0;
         RDATA_O  <= 32'h0000_0000;
      end else begin
         code     <= next_code;
         hw_oc_en <= next_hw_oc_en;
         reject   <= next_reject;
         RDATA_O  <= next_rdata;
      end
   end

   // Running hysteresis and limiting timers
   always_comb begin
      // Hardware overcurrent counts only when software enabled it
      limit_any = STATE_I.torque_limiting | STATE_I.sw_current_limiting |
                  (STATE_I.hw_oc_limiting & hw_oc_en) | STATE_I.anti_regen_decel;
      next_run_state = run_state;
      if (STATE_I.freq_above_start) begin
         next_run_state = 1'b1;
      end else if (STATE_I.freq_below_stop) begin
         next_run_state = 1'b0;
      end
      // Reload keeps every pulse at least the minimum width
      if (limit_any) begin
         next_hold_cnt = LIMIT_MIN;
      end else if (hold_cnt != 22'h00_0000) begin
         next_hold_cnt = hold_cnt - 22'h00_0001;
      end else begin
         next_hold_cnt = hold_cnt;
      end
      // Any gap restarts the continuity count
      if (!limit_any) begin
         next_dly_cnt = 22'h00_0000;
      end else if (dly_cnt < LIMIT_DLY) begin
         next_dly_cnt = dly_cnt + 22'h00_0001;
      end else begin
         next_dly_cnt = dly_cnt;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         run_state <= 1'b0;
         hold_cnt  <= 22'h00_0000;
         dly_cnt   <= 22'h00_0000;
      end else begin
         run_state <= next_run_state;
         hold_cnt  <= next_hold_cnt;
         dly_cnt   <= next_dly_cnt;
      end
   end

   // Supply contactor sequence; alarm and coast override any pending stop
   always_comb begin
      next_ax_state = ax_state;
      case (ax_state)
         DSO_AX_OFF: begin
            // Undervoltage taken from the sampled state so a run in that cycle is refused
            if (STATE_I.forward_run_command &&
                !(STATE_I.dc_link_below_uv | STATE_I.uv_trip) &&
                !STATE_I.any_alarm && !STATE_I.coast_command) begin
               next_ax_state = DSO_AX_ON;
            end
         end
         DSO_AX_ON: begin
            if (STATE_I.stop_command) begin
               next_ax_state = DSO_AX_STOPPING;
            end
         end
         DSO_AX_STOPPING: begin
            if (STATE_I.motor_stopped) begin
               next_ax_state = DSO_AX_OFF;
            end else if (STATE_I.forward_run_command &&
                         !(STATE_I.dc_link_below_uv | STATE_I.uv_trip)) begin
               next_ax_state = DSO_AX_ON;
            end
         end
         default: next_ax_state = DSO_AX_OFF;
      endcase
      if (STATE_I.coast_command || STATE_I.any_alarm) begin
         next_ax_state = DSO_AX_OFF;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ax_state <= DSO_AX_OFF;
      end else begin
         ax_state <= next_ax_state;
      end
   end

   // Function flags
   always_comb begin
      vec_hold = STATE_I.vector_mode & (STATE_I.zero_speed_ctl | STATE_I.servo_lock);
      next_flags.running = (next_run_state & ~STATE_I.dc_braking &
                            ~STATE_I.dew_prevention) | vec_hold;
      next_flags.output_on = next_run_state | STATE_I.dc_braking | STATE_I.pre_exciting |
                             STATE_I.zero_speed_ctl | STATE_I.dew_prevention |
                             vec_hold;
      next_flags.undervoltage_flag = STATE_I.dc_link_below_uv | STATE_I.uv_trip;
      next_flags.torque_polarity = STATE_I.torque_braking;
      next_flags.output_limiting_flag = limit_any | (next_hold_cnt != 22'h00_0000);
      next_flags.output_limiting_delayed_flag = (next_dly_cnt >= LIMIT_DLY);
      next_flags.keypad_run_source_flag = STATE_I.keypad_run_source;
      next_flags.ready = STATE_I.prep_done & ~STATE_I.protective_active;
      next_flags.supply_contactor_control = (next_ax_state != DSO_AX_OFF);
      next_flags.any_alarm_flag = STATE_I.any_alarm;
      // Run commands pass only while undervoltage is clear
      next_run_enable = ~next_flags.undervoltage_flag;
      for (int i = 0; i < DSO_NUM_TERM; i++) begin
         next_term[i] = dso_select(code[i], next_flags, STATE_I.custom_logic);
      end
   end

   // Terminals refresh every control cycle from the next flags, in step with flags
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         flags            <= '0;
         TERM_O           <= '0;
         RUN_CMD_ENABLE_O <= 1'b0;
      end else begin
         flags            <= next_flags;
         TERM_O           <= next_term;
         RUN_CMD_ENABLE_O <= next_run_enable;
      end
   end

endmodule : dso_top

// ==== verif/dso_term_reader.sv ====
// Equipment watching one status terminal and timing its high pulses
module dso_term_reader (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Terminal and measured width
   input  wire logic term_i,
   output int        width_o
);
   int run_len;

   // Samples on the control clock, so widths are in whole cycles
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         run_len <= 0;
         width_o <= 0;
      end else if (term_i) begin
         run_len <= run_len + 1;
      end else begin
         if (run_len != 0) begin
            width_o <= run_len;
         end
         run_len <= 0;
      end
   end
endmodule : dso_term_reader

// ==== verif/dso_top_assertions.sv ====
// Port checker for the status output block
module dso_top_assertions
   import dso_pkg::*;
#(
   parameter int LIMIT_MIN_CYC = 20
) (
   // Clock, reset and register port
   input wire logic                    CLK_I,
   input wire logic                    RST_I,
   input wire logic [7:0]              ADDR_I,
   input wire logic [31:0]             WDATA_I,
   input wire logic                    WR_I,
   input wire logic                    RD_I,
   input wire logic [31:0]             RDATA_O,
   // Drive state and outputs
   input wire dso_state_s              STATE_I,
   input wire logic                    RUN_CMD_ENABLE_O,
   input wire logic [DSO_NUM_TERM-1:0] TERM_O
);
   logic        live;
   logic [4:0]  dflt;
   logic [15:0] hi_cnt;

   // Terminal checks hold only while that terminal keeps its reset code
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         live   <= 1'b0;
         dflt   <= 5'h1f;
         hi_cnt <= 16'h0000;
      end else begin
         live   <= 1'b1;
         hi_cnt <= TERM_O[2] ? hi_cnt + 16'h0001 : 16'h0000;
         if (WR_I && ADDR_I <= 8'h10 && ADDR_I[1:0] == 2'b00) begin
            dflt[ADDR_I[4:2]] <= 1'b0;
         end
      end
   end

   default clocking dcb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);

   // Read data stands only in the cycle after a read
   property p_rdata_idle;
      !$past(RD_I) |-> RDATA_O == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
   property p_run_gate;
      live |-> RUN_CMD_ENABLE_O == !($past(STATE_I.dc_link_below_uv) || $past(STATE_I.uv_trip));
   endproperty
   a_run_gate: assert property (p_run_gate) else $error("run gate wrong");
   property p_uv_term;
      live && dflt[1] |-> TERM_O[1] == ($past(STATE_I.dc_link_below_uv) | $past(STATE_I.uv_trip));
   endproperty
   a_uv_term: assert property (p_uv_term) else $error("undervoltage terminal wrong");
   property p_ready;
      live && dflt[3] |-> TERM_O[3] == ($past(STATE_I.prep_done) & ~$past(STATE_I.protective_active));
   endproperty
   a_ready: assert property (p_ready) else $error("ready terminal wrong");
   property p_alarm;
      live && dflt[4] |-> TERM_O[4] == $past(STATE_I.any_alarm);
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm terminal wrong");
   // Limiting must show at once and then last its minimum width
   property p_lim_src;
      live && dflt[2] && $past(STATE_I.torque_limiting) |-> TERM_O[2];
   endproperty
   a_lim_src: assert property (p_lim_src) else $error("limiting not shown");
   property p_lim_width;
      live && dflt[2] && $fell(TERM_O[2]) |-> hi_cnt >= LIMIT_MIN_CYC;
   endproperty
   a_lim_width: assert property (p_lim_width) else $error("limiting pulse too short");
   property p_dcb_run;
      live && dflt[0] && $past(STATE_I.dc_braking) && !$past(STATE_I.vector_mode) |-> !TERM_O[0];
   endproperty
   a_dcb_run: assert property (p_dcb_run) else $error("running on while braking");
   property p_vec_run;
      live && dflt[0] && $past(STATE_I.vector_mode) && $past(STATE_I.servo_lock) |-> TERM_O[0];
   endproperty
   a_vec_run: assert property (p_vec_run) else $error("running off under servo lock");
endmodule : dso_top_assertions

bind dso_top dso_top_assertions #(.LIMIT_MIN_CYC(LIMIT_MIN_CYC)) u_chk (
   .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
   .RD_I(RD_I), .RDATA_O(RDATA_O), .STATE_I(STATE_I),
   .RUN_CMD_ENABLE_O(RUN_CMD_ENABLE_O), .TERM_O(TERM_O));

// ==== verif/tb_drive_status_output_logic.sv ====
// Self-checking bench for the status output block
`include "dso_map.svh"
module tb_drive_status_output_logic
   import dso_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIM = 20;
   localparam int DLY = 5;
   logic                    CLK_I = 1'b0;
   logic                    RST_I = 1'b1;
   logic [7:0]              ADDR_I = 8'h00;
   logic [31:0]             WDATA_I = 32'h0000_0000;
   logic                    WR_I = 1'b0;
   logic                    RD_I = 1'b0;
   logic [31:0]             RDATA_O;
   dso_state_s              STATE_I = '0;
   logic                    RUN_CMD_ENABLE_O;
   logic [DSO_NUM_TERM-1:0] TERM_O;
   logic [31:0]             rdat;
   dso_state_s              st;
   int                      n_errors = 0;
   int                      tests_run = 0;
   int                      lim_w;
   int                      i;
   int                      c;
   int                      tbl [10] = '{3, 4, 8, 10, 99, 111, 112, 113, 114, 115};
   int                      dflt [5] = '{0, 3, 5, 10, 99};
   // Running table: above, below, braking, dew, zero, servo, vector; run, on, inverted run
   logic [9:0]              run_tbl [9] = '{10'b0100000_001, 10'b1000000_110,
      10'b0000000_110, 10'b0010000_011, 10'b0001000_011, 10'b0100000_001,
      10'b0000011_110, 10'b0000101_110, 10'b0100000_001};
   // Contactor table: forward, stop, stopped, coast, alarm, undervoltage; expected
   logic [6:0]              con_tbl [11] = '{7'b000100_0, 7'b100000_1, 7'b000000_1,
      7'b010000_1, 7'b000000_1, 7'b001000_0, 7'b100000_1, 7'b000100_0, 7'b100000_1,
      7'b000010_0, 7'b100001_0};

   always #20 CLK_I = ~CLK_I;

   dso_top #(.LIMIT_MIN_CYC(LIM), .LIMIT_DLY_CYC(DLY)) DUT (
      .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
      .RD_I(RD_I), .RDATA_O(RDATA_O), .STATE_I(STATE_I),
      .RUN_CMD_ENABLE_O(RUN_CMD_ENABLE_O), .TERM_O(TERM_O));

   dso_term_reader u_rdr (.clk_i(CLK_I), .rst_i(RST_I), .term_i(TERM_O[2]), .width_o(lim_w));

   task automatic step(input int n);
      repeat (n) @(posedge CLK_I);
   endtask : step

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ADDR_I  <= a;
      WDATA_I <= d;
      WR_I    <= 1'b1;
      step(1);
      WR_I    <= 1'b0;
      step(1);
   endtask : wr

   // Read data is taken at the edge that closes its one standing cycle
   task automatic rd(input logic [7:0] a);
      ADDR_I <= a;
      RD_I   <= 1'b1;
      step(1);
      RD_I   <= 1'b0;
      step(1);
      rdat = RDATA_O;
   endtask : rd

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic wait_term(input int b, input logic v);
      int n;
      for (n = 0; n < 200 && TERM_O[b] !== v; n++) begin
         step(1);
      end
      if (n == 200) begin
         n_errors++;
         end_sim();
      end
   endtask : wait_term

   // Reference for the flags that follow the drive state directly
   function automatic logic comb_flag(input int code, input dso_state_s s);
      case (code % 1000)
         3: return s.dc_link_below_uv | s.uv_trip;
         4: return s.torque_braking;
         8: return s.keypad_run_source;
         10: return s.prep_done & ~s.protective_active;
         99: return s.any_alarm;
         default: return s.custom_logic[code % 1000 - 111];
      endcase
   endfunction : comb_flag

   function automatic dso_state_s lim_st(input int k);
      dso_state_s s;
      s = '0;
      case (k)
         0: s.torque_limiting = 1'b1;
         1: s.sw_current_limiting = 1'b1;
         2: s.hw_oc_limiting = 1'b1;
         3: s.anti_regen_decel = 1'b1;
         default: s.prep_done = 1'b1;
      endcase
      return s;
   endfunction : lim_st

   // Main sequence
   initial begin
      void'($urandom(32'h0000_3cc7));
      step(12);
      RST_I <= 1'b0;
      step(1);
      chk(TERM_O, 0);
      for (i = 0; i < 5; i++) begin
         rd(8'(4 * i));
         chk(rdat, dflt[i]);
      end
      rd(8'h20);
      chk(rdat, 0);
      // First ten states under reset codes, then each code of tbl in both polarities
      for (i = 0; i < 50; i++) begin
         c = (i < 10) ? 99 : tbl[i % 10] + ((i / 10) % 2) * 1000;
         st = dso_state_s'(29'($urandom));
         if (i >= 10) begin
            wr(`DSO_REG_CODE4, 32'(c));
         end
         STATE_I <= st;
         step(2);
         chk(TERM_O[4], comb_flag(c, st) ^ (c >= 1000));
         chk(RUN_CMD_ENABLE_O, !(st.dc_link_below_uv || st.uv_trip));
      end
      wr(`DSO_REG_CODE3, 32'd1011);
      rd(`DSO_REG_CODE3);
      chk(rdat, 10);
      rd(`DSO_REG_STATUS);
      chk(rdat[0], 1'b1);
      wr(`DSO_REG_STATUS, 32'h0000_0001);
      rd(`DSO_REG_STATUS);
      chk(rdat[0], 1'b0);
      wr(`DSO_REG_CODE3, 32'd22);
      wr(`DSO_REG_CTRL, 32'h0000_0001);
      STATE_I <= lim_st(4);
      wait_term(2, 1'b0);
      // Each limiting source: a one-cycle pulse, then a sustained run
      for (i = 0; i < 4; i++) begin
         STATE_I <= lim_st(i);
         step(1);
         STATE_I <= lim_st(4);
         step(1);
         chk(TERM_O[3:2], 2'b01);
         wait_term(2, 1'b0);
         step(1);
         chk((lim_w >= LIM) && (lim_w <= LIM + 2), 1'b1);
         STATE_I <= lim_st(i);
         step(DLY - 1);
         chk(TERM_O[3], 1'b0);
         step(3);
         chk(TERM_O[3:2], 2'b11);
         STATE_I <= lim_st(4);
         wait_term(2, 1'b0);
      end
      wr(`DSO_REG_CTRL, 32'h0000_0000);
      STATE_I <= lim_st(2);
      step(3);
      chk(TERM_O[2], 1'b0);
      wr(`DSO_REG_CODE1, 32'd35);
      wr(`DSO_REG_CODE2, 32'd1000);
      for (i = 0; i < 9; i++) begin
         st = '0;
         {st.freq_above_start, st.freq_below_stop, st.dc_braking, st.dew_prevention,
          st.zero_speed_ctl, st.servo_lock, st.vector_mode} = run_tbl[i][9:3];
         STATE_I <= st;
         step(2);
         chk({TERM_O[0], TERM_O[1], TERM_O[2]}, run_tbl[i][2:0]);
      end
      wr(`DSO_REG_CODE1, 32'd15);
      for (i = 0; i < 11; i++) begin
         st = '0;
         {st.forward_run_command, st.stop_command, st.motor_stopped, st.coast_command,
          st.any_alarm, st.dc_link_below_uv} = con_tbl[i][6:1];
         STATE_I <= st;
         step(2);
         chk(TERM_O[1], con_tbl[i][0]);
      end
      RST_I <= 1'b1;
      step(2);
      RST_I <= 1'b0;
      step(1);
      rd(`DSO_REG_CODE1);
      chk(rdat, 3);
      end_sim();
   end
endmodule : tb_drive_status_output_logic
